// >>> hw/macrocell_pkg.sv
// Purpose: Shared constants and types for the output macrocell array.
// Assumes: APB register map with 32-bit data, one aligned word per register.
// Notes: Term words hold true/complement literal enables for the array.
package macrocell_pkg;

  // ************************************************************
  // Array geometry
  // ************************************************************
  localparam int CELLS = 8;
  localparam int TERMS = 8;
  localparam int DED_INPUTS = 8;
  localparam int ARRAY_INPUTS = DED_INPUTS + CELLS;
  localparam int TERM_WORDS = CELLS * TERMS;
  localparam int INNER_LO = 3;
  localparam int INNER_HI = 4;
  localparam int OUTER_LO = 0;
  localparam int OUTER_HI = 7;

  // ************************************************************
  // Register offsets (byte addresses) and the term page number (address bits 11:8)
  // ************************************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_POLARITY = 12'h004;
  localparam logic [11:0] OFS_DIRECTION = 12'h008;
  localparam logic [11:0] OFS_TERM_DIS_LO = 12'h00c;
  localparam logic [11:0] OFS_TERM_DIS_HI = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [3:0] OFS_TERM_PAGE = 4'h1;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL_SYNC_POS = 0;
  localparam int CTRL_ARCH_POS = 1;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_REGQ_LSB = 8;
  localparam int STAT_DRIVE_LSB = 16;
  localparam int STAT_OE_LSB = 24;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic RST_SYNC = 1'b1;
  localparam logic RST_ARCH = 1'b0;
  localparam logic [7:0] RST_POLARITY = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hff;
  localparam logic [63:0] RST_TERM_DIS = 64'hffffffffffffffff;
  localparam logic [31:0] RST_TERM_WORD = 32'h00000000;

  // Global macrocell modes, one-hot.
  typedef enum logic [2:0] {
    MODE_REGISTERED = 3'b001,
    MODE_COMPLEX = 3'b010,
    MODE_SIMPLE = 3'b100
  } mode_t;

endpackage

// >>> hw/output_macrocell_array.sv
// Purpose: Eight output macrocells with global mode and per-cell bits.
// Assumes: Board pins are asynchronous and are synchronised here.
// Notes: Configuration and product-term words are reached over APB.
`timescale 1ns/1ns

module output_macrocell_array
  import macrocell_pkg::*;
#(
  parameter int CELL_COUNT = CELLS,
  parameter int TERM_COUNT = TERMS
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [DED_INPUTS-1:0] data_pin_i,
  input wire logic clk_pin_i,
  input wire logic oe_n_pin_i,
  input wire logic [CELLS-1:0] cell_pin_i,
  output logic [CELLS-1:0] cell_pin_o,
  output logic [CELLS-1:0] cell_pin_oe_o
);

  // ************************************************************
  // Elaboration check
  // ************************************************************
  // Feedback routing is wired for exactly eight cells of eight terms.
  if (CELL_COUNT != CELLS || TERM_COUNT != TERMS) begin : g_bad_size
    $error("output_macrocell_array supports only 8 cells of 8 terms");
  end

  localparam int SYNC_W = DED_INPUTS + CELLS + 2;

  // ************************************************************
  // Configuration state
  // ************************************************************
  logic sync_mode_bit_r;
  logic global_arch_bit_r;
  logic [CELLS-1:0] polarity_r;
  logic [CELLS-1:0] cell_direction_bit_r;
  logic [TERM_WORDS-1:0] term_disable_fuse_r;
  logic [31:0] term_mem [TERM_WORDS];
  mode_t mode;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic clk_prev_r;
  logic [DED_INPUTS-1:0] in_s;
  logic [CELLS-1:0] cell_s;
  logic clk_s;
  logic oe_n_s;
  logic clk_rise;

  // Two flops per pin; only the second stage is read by logic.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
      clk_prev_r <= 1'b0;
    end else begin
      sync1_r <= {oe_n_pin_i, clk_pin_i, cell_pin_i, data_pin_i};
      sync2_r <= sync1_r;
      clk_prev_r <= sync2_r[SYNC_W-2];
    end
  end

  assign in_s = sync2_r[DED_INPUTS-1:0];
  assign cell_s = sync2_r[DED_INPUTS+CELLS-1:DED_INPUTS];
  assign clk_s = sync2_r[SYNC_W-2];
  assign oe_n_s = sync2_r[SYNC_W-1];
  // The shared clock pin is sampled, so its edge is a one-cycle enable.
  assign clk_rise = clk_s & ~clk_prev_r;

  // ************************************************************
  // Mode decode
  // ************************************************************
  // Sync bit low selects registered; otherwise the arch bit decides.
  always_comb begin
    if (!sync_mode_bit_r) begin
      mode = MODE_REGISTERED;
    end else if (global_arch_bit_r) begin
      mode = MODE_COMPLEX;
    end else begin
      mode = MODE_SIMPLE;
    end
  end

  // ************************************************************
  // Feedback routing into the array
  // ************************************************************
  logic [CELLS-1:0] cell_q_r;
  logic [CELLS-1:0] fb;
  logic [ARRAY_INPUTS-1:0] arr_in;

  // Inner slots carry nothing in complex mode; outside registered mode the
  // outer slots 0 and 7 are lent to the clock and enable pins.
  always_comb begin
    fb = '0;
    case (mode)
      MODE_REGISTERED: begin
        for (int c = 0; c < CELLS; c++) begin
          // Register cells feed back their state, I/O cells their pin.
          fb[c] = cell_direction_bit_r[c] ? cell_s[c] : cell_q_r[c];
        end
      end
      MODE_COMPLEX: begin
        fb[OUTER_LO] = clk_s;
        fb[OUTER_HI] = oe_n_s;
        for (int c = OUTER_LO + 1; c < INNER_LO; c++) begin
          fb[c] = cell_s[c];
        end
        for (int c = INNER_HI + 1; c < OUTER_HI; c++) begin
          fb[c] = cell_s[c];
        end
      end
      MODE_SIMPLE: begin
        fb[OUTER_LO] = clk_s;
        fb[OUTER_HI] = oe_n_s;
        // Slots 1 to 6 each carry the pin of their outer neighbour.
        for (int c = OUTER_LO + 1; c <= INNER_LO; c++) begin
          fb[c] = cell_s[c-1];
        end
        for (int c = INNER_HI; c < OUTER_HI; c++) begin
          fb[c] = cell_s[c+1];
        end
      end
      default: begin
        fb = '0;
      end
    endcase
  end

  assign arr_in = {fb, in_s};

  // ************************************************************
  // Product terms and sums
  // ************************************************************
  // Bit 2k enables input k true, bit 2k+1 enables it complemented.
  function automatic logic term_eval(input logic [31:0] f,
                                     input logic [ARRAY_INPUTS-1:0] v);
    logic r;
    r = 1'b1;
    for (int k = 0; k < ARRAY_INPUTS; k++) begin
      if (f[2*k] && !v[k]) r = 1'b0;
      if (f[2*k+1] && v[k]) r = 1'b0;
    end
    return r;
  endfunction

  logic [TERMS-1:0] terms [CELLS];
  logic [CELLS-1:0] sum_all;
  logic [CELLS-1:0] sum_io;
  logic [CELLS-1:0] term_oe;

  // A disabled term contributes nothing to its sum or enable.
  always_comb begin
    for (int c = 0; c < CELLS; c++) begin
      for (int t = 0; t < TERMS; t++) begin
        terms[c][t] = term_eval(term_mem[c*TERMS+t], arr_in) &
                      ~term_disable_fuse_r[c*TERMS+t];
      end
      sum_all[c] = |terms[c];
      sum_io[c] = |terms[c][TERMS-1:1];
      term_oe[c] = terms[c][0];
    end
  end

  // ************************************************************
  // Macrocell registers
  // ************************************************************
  // Only register cells in registered mode take the shared clock.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cell_q_r <= '0;
    end else if (clk_rise && mode == MODE_REGISTERED) begin
      for (int c = 0; c < CELLS; c++) begin
        if (!cell_direction_bit_r[c]) begin
          cell_q_r[c] <= sum_all[c];
        end
      end
    end
  end

  // ************************************************************
  // Pin drive and output enable
  // ************************************************************
  logic [CELLS-1:0] drive_nxt;
  logic [CELLS-1:0] oe_nxt;

  always_comb begin
    drive_nxt = '0;
    oe_nxt = '0;
    for (int c = 0; c < CELLS; c++) begin
      case (mode)
        MODE_REGISTERED: begin
          if (!cell_direction_bit_r[c]) begin
            drive_nxt[c] = cell_q_r[c] ^ polarity_r[c];
            oe_nxt[c] = ~oe_n_s;
          end else begin
            drive_nxt[c] = sum_io[c] ^ polarity_r[c];
            oe_nxt[c] = term_oe[c];
          end
        end
        MODE_COMPLEX: begin
          drive_nxt[c] = sum_io[c] ^ polarity_r[c];
          oe_nxt[c] = term_oe[c];
        end
        MODE_SIMPLE: begin
          drive_nxt[c] = sum_all[c] ^ polarity_r[c];
          // Inner cells have no input path, so they always drive.
          oe_nxt[c] = ~cell_direction_bit_r[c] ||
                      c == INNER_LO || c == INNER_HI;
        end
        default: begin
          drive_nxt[c] = 1'b0;
          oe_nxt[c] = 1'b0;
        end
      endcase
    end
  end

  // Pins are registered, adding one cycle but keeping outputs glitch free.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cell_pin_o <= '0;
      cell_pin_oe_o <= '0;
    end else begin
      cell_pin_o <= drive_nxt;
      cell_pin_oe_o <= oe_nxt;
    end
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  logic access;
  logic wr_en;
  logic term_hit;
  logic [5:0] term_idx;
  logic [31:0] rd_data;
  logic rd_err;

  // One wait state: pready rises in the second access cycle.
  assign access = psel_i & penable_i;
  assign wr_en = access & pready_o & pwrite_i;
  assign term_hit = paddr_i[11:8] == OFS_TERM_PAGE;
  assign term_idx = paddr_i[7:2];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // Read mux; unmapped addresses answer with an error.
  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    if (term_hit) begin
      rd_data = term_mem[term_idx];
    end else begin
      case (paddr_i)
        OFS_CTRL: begin
          rd_data[CTRL_SYNC_POS] = sync_mode_bit_r;
          rd_data[CTRL_ARCH_POS] = global_arch_bit_r;
        end
        OFS_POLARITY: rd_data[CELLS-1:0] = polarity_r;
        OFS_DIRECTION: rd_data[CELLS-1:0] = cell_direction_bit_r;
        OFS_TERM_DIS_LO: rd_data = term_disable_fuse_r[31:0];
        OFS_TERM_DIS_HI: rd_data = term_disable_fuse_r[63:32];
        OFS_STATUS: begin
          rd_data[STAT_MODE_LSB +: 3] = mode;
          rd_data[STAT_REGQ_LSB +: CELLS] = cell_q_r;
          rd_data[STAT_DRIVE_LSB +: CELLS] = cell_pin_o;
          rd_data[STAT_OE_LSB +: CELLS] = cell_pin_oe_o;
        end
        default: rd_err = 1'b1;
      endcase
    end
  end

  // Handshake and read capture.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end else begin
      pready_o <= access & ~pready_o;
      pslverr_o <= access & ~pready_o & rd_err;
      prdata_o <= (access & ~pready_o & ~pwrite_i) ? rd_data : '0;
    end
  end

  // Control registers; all cells follow the one global mode.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      sync_mode_bit_r <= RST_SYNC;
      global_arch_bit_r <= RST_ARCH;
      polarity_r <= RST_POLARITY;
      cell_direction_bit_r <= RST_DIRECTION;
      term_disable_fuse_r <= RST_TERM_DIS;
    end else if (wr_en && !term_hit) begin
      case (paddr_i)
        OFS_CTRL: begin
          if (pstrb_i[0]) begin
            sync_mode_bit_r <= pwdata_i[CTRL_SYNC_POS];
            global_arch_bit_r <= pwdata_i[CTRL_ARCH_POS];
          end
        end
        OFS_POLARITY: begin
          if (pstrb_i[0]) polarity_r <= pwdata_i[CELLS-1:0];
        end
        OFS_DIRECTION: begin
          if (pstrb_i[0]) begin
            cell_direction_bit_r <= pwdata_i[CELLS-1:0];
          end
        end
        OFS_TERM_DIS_LO: begin
          term_disable_fuse_r[31:0] <=
            merge(term_disable_fuse_r[31:0], pwdata_i, pstrb_i);
        end
        OFS_TERM_DIS_HI: begin
          term_disable_fuse_r[63:32] <=
            merge(term_disable_fuse_r[63:32], pwdata_i, pstrb_i);
        end
        default: begin
          sync_mode_bit_r <= sync_mode_bit_r;
        end
      endcase
    end
  end

  // Product-term words, one per term, cell-major.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < TERM_WORDS; i++) begin
        term_mem[i] <= RST_TERM_WORD;
      end
    end else if (wr_en && term_hit) begin
      term_mem[term_idx] <= merge(term_mem[term_idx], pwdata_i, pstrb_i);
    end
  end

endmodule // output_macrocell_array

// >>> verification/macrocell_monitor.sv
// Purpose: Port-level checks on the output macrocell array.
// Assumes: One wait state APB slave, pins synchronised inside.
// Notes: Bound to the design top by port name.
`timescale 1ns/1ns

module macrocell_monitor
  import macrocell_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [DED_INPUTS-1:0] data_pin_i,
  input wire logic clk_pin_i,
  input wire logic oe_n_pin_i,
  input wire logic [CELLS-1:0] cell_pin_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [CELLS-1:0] cell_pin_o,
  input wire logic [CELLS-1:0] cell_pin_oe_o
);
  // ****************************************************
  // Assertions
  // ****************************************************
  // All checks share the one clock and its reset.
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_reset_quiet: assert property ($rose(reset_n_i) |->
    (cell_pin_oe_o == 8'h00 && pready_o == 1'b0))
    else $error("outputs not quiet after reset");
  a_inner_drive: assert property ($rose(reset_n_i) |-> ##2
    cell_pin_oe_o == 8'h18) else $error("inner cells not driving");
  a_one_wait: assert property ((psel_i && !penable_i) ##1
    (psel_i && penable_i) |=> pready_o) else $error("no ready");
  a_ready_single: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("ready without access");
  a_idle_ready: assert property (!psel_i |=> !pready_o)
    else $error("ready while idle");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_data_zero: assert property (!pready_o |-> prdata_o == 32'h00000000)
    else $error("read data outside ready");
  // Nothing may move at the pins unless an input or a register write moved.
  a_pins_settle: assert property (($stable(data_pin_i) &&
    $stable(clk_pin_i) && $stable(oe_n_pin_i) && $stable(cell_pin_i) &&
    !psel_i) [*6] |-> ($stable(cell_pin_o) && $stable(cell_pin_oe_o)))
    else $error("pins changed without cause");
endmodule // macrocell_monitor

bind output_macrocell_array macrocell_monitor u_mon (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .data_pin_i(data_pin_i), .clk_pin_i(clk_pin_i),
  .oe_n_pin_i(oe_n_pin_i), .cell_pin_i(cell_pin_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .cell_pin_o(cell_pin_o),
  .cell_pin_oe_o(cell_pin_oe_o));

// >>> verification/board_model.sv
// Purpose: Board logic that drives the device pins and reads its outputs.
// Assumes: Board levels change just after a rising system clock edge.
// Notes: Clock pin pulses stay high for four cycles, then low for at least three.
`timescale 1ns/1ns

module board_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] drive_i,
  input wire logic [7:0] drive_en_i,
  output logic [7:0] data_o,
  output logic clk_o,
  output logic oe_n_o,
  output logic [7:0] cell_o
);
  // ****************************************************
  // Pin levels
  // ****************************************************
  // Undriven cells see a board pattern, never a copy of the last output.
  assign cell_o = (drive_en_i & drive_i) | (~drive_en_i & 8'h5a);

  // Board starts with registered outputs disabled.
  initial begin
    data_o = 8'h00;
    clk_o = 1'b0;
    oe_n_o = 1'b1;
  end

  task automatic set_data(input logic [7:0] v);
    @(posedge ref_clk_i);
    data_o <= v;
  endtask

  task automatic set_clk(input logic v);
    @(posedge ref_clk_i);
    clk_o <= v;
  endtask

  task automatic set_oe_n(input logic v);
    @(posedge ref_clk_i);
    oe_n_o <= v;
  endtask

  // Each level is held long enough for the synchroniser to see it.
  task automatic pulse_clk();
    set_clk(1'b1);
    repeat (3) @(posedge ref_clk_i);
    set_clk(1'b0);
    repeat (3) @(posedge ref_clk_i);
  endtask
endmodule // board_model

// >>> verification/output_macrocell_mode_config_tb_top.sv
// Purpose: Self-checking bench for the output macrocell array.
// Assumes: APB slave answers with one wait state.
// Notes: Scenarios run simple, complex then registered mode.
`timescale 1ns/1ns

module output_macrocell_mode_config_tb_top;
  import macrocell_pkg::*;
  logic ref_clk_i, reset_n_i, psel, penable, pwrite, pready, pslverr, cpin;
  logic oen;
  logic [3:0] pstrb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] dpin, cin, cout, coe;
  int err_count, n_compared;

  // ****************************************************
  // Structure
  // ****************************************************
  output_macrocell_array dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .data_pin_i(dpin), .clk_pin_i(cpin),
    .oe_n_pin_i(oen), .cell_pin_i(cin), .cell_pin_o(cout),
    .cell_pin_oe_o(coe));
  board_model board (.ref_clk_i(ref_clk_i), .drive_i(cout),
    .drive_en_i(coe), .data_o(dpin), .clk_o(cpin), .oe_n_o(oen),
    .cell_o(cin));

  // Free-running 250 MHz system clock.
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Request is held until pready is seen at an edge, then released.
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1, "apb hang");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(a, 1'b1, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] m, x);
    logic [31:0] q;
    logic e;
    apb(a, 1'b0, 32'h0, q, e);
    chk(q & m, x, "register read");
  endtask

  // Longer than any pin path, so outputs are settled when looked at.
  task automatic settle();
    repeat (8) @(posedge ref_clk_i);
  endtask

  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rd(OFS_CTRL, 32'h3, 32'h1);
    rd(OFS_POLARITY, 32'hff, 32'h0);
    rd(OFS_DIRECTION, 32'hff, 32'hff);
    rd(OFS_STATUS, 32'hff000007, 32'h18000004);
    apb(12'h020, 1'b0, 32'h0, q, e);
    chk(e, 1'b1, "unmapped error");
    // Strobes change only between transfers, so each request sees one value.
    pstrb <= 4'he;
    wr(OFS_POLARITY, 32'hff);
    rd(OFS_POLARITY, 32'hff, 32'h0);
    pstrb <= 4'h2;
    wr(12'h1fc, 32'hffffffff);
    pstrb <= 4'hf;
    rd(12'h1fc, 32'hffffffff, 32'h0000ff00);
  endtask

  // Cell 3 sums data pin 0; cell 4 sums the clock pin as plain data.
  task automatic t_simple();
    wr(12'h160, 32'h1);
    wr(12'h180, 32'h00010000);
    wr(OFS_TERM_DIS_LO, 32'hfeffffff);
    wr(OFS_TERM_DIS_HI, 32'hfffffffe);
    board.set_data(8'h01);
    settle();
    chk(cout[3], 1'b1, "simple sum");
    chk(coe[4:3], 2'b11, "inner drive");
    wr(OFS_POLARITY, 32'h08);
    settle();
    chk(cout[3], 1'b0, "polarity");
    board.set_data(8'h00);
    settle();
    chk(cout[3], 1'b1, "polarity low");
    wr(OFS_POLARITY, 32'h0);
    board.set_clk(1'b1);
    settle();
    chk(cout[4], 1'b1, "clock pin as data");
    board.set_clk(1'b0);
    // Cell 1 becomes an output; its pin reaches cell 3 through slot 2.
    wr(12'h164, 32'h00100000);
    wr(OFS_TERM_DIS_LO, 32'hfcffffff);
    wr(OFS_DIRECTION, 32'hfd);
    wr(OFS_POLARITY, 32'h02);
    settle();
    chk(coe[1], 1'b1, "simple output on");
    chk(cout[3], 1'b1, "adjacent feedback");
    wr(OFS_POLARITY, 32'h0);
    settle();
    chk(cout[3], 1'b0, "adjacent follows");
  endtask

  // Term 0 becomes the enable term; clock pin feeds the array.
  task automatic t_complex();
    wr(OFS_CTRL, 32'h3);
    rd(OFS_STATUS, 32'h7, 32'h2);
    board.set_clk(1'b1);
    settle();
    chk(coe[4], 1'b1, "enable term on");
    chk(coe[3], 1'b0, "enable term off");
    board.set_clk(1'b0);
    settle();
    chk(coe[4], 1'b0, "enable follows");
  endtask

  // Cell 0 is a register, cell 3 a combinatorial I/O.
  task automatic t_registered();
    wr(OFS_CTRL, 32'h0);
    wr(OFS_DIRECTION, 32'hfe);
    wr(OFS_TERM_DIS_LO, 32'hfefffffe);
    wr(12'h100, 32'h1);
    settle();
    chk(coe[0], 1'b0, "oe pin high floats");
    board.set_oe_n(1'b0);
    settle();
    chk(coe[0], 1'b1, "oe pin low drives");
    chk(cout[0], 1'b0, "power-up value");
    // Slot 0 must carry the register, so a high clock pin is not seen.
    board.set_clk(1'b1);
    settle();
    chk(coe[4], 1'b0, "clock pin not data");
    board.set_clk(1'b0);
    board.set_data(8'h01);
    settle();
    chk(cout[0], 1'b0, "no clock no capture");
    chk(coe[3], 1'b1, "io enable term");
    board.pulse_clk();
    settle();
    chk(cout[0], 1'b1, "captured");
    chk(coe[4], 1'b1, "register feeds back");
    rd(OFS_STATUS, 32'h0000ff07, 32'h00000101);
    board.set_oe_n(1'b1);
    settle();
    chk(coe[0], 1'b0, "disabled again");
  endtask

  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************************
  // Sequence
  // ****************************************************
  // Watchdog sits well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    wrap_up();
  end

  // Reset for six cycles, then the scenarios in mode order.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    reset_n_i = 1'b0;
    err_count = 0;
    n_compared = 0;
    repeat (6) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    t_reset();
    t_simple();
    t_complex();
    t_registered();
    wrap_up();
  end
endmodule // output_macrocell_mode_config_tb_top
